// ===== design/ibsf_pkg.sv
package ibsf_pkg;
   // Byte address width of the register port
   localparam int ADDR_W = 18;
   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_CTRL = 16'hffa6;
   localparam logic [15:0] IDX_STAT = 16'hffaa;
   localparam logic [15:0] IDX_FLAG = 16'hffab;
   localparam logic [15:0] IDX_INT_STAT = 16'hffb0;
   localparam logic [15:0] IDX_INT_CLR = 16'hffb1;
   localparam logic [15:0] IDX_INT_EN = 16'hffb2;
   // Control register fields
   localparam int CTRL_ENABLE_BIT = 7;
   localparam int CTRL_EXIT_BIT = 6;
   localparam int CTRL_START_BIT = 1;
   // Status register fields
   localparam int STAT_STOP_BIT = 0;
   // Flag register fields
   localparam int FLAG_FAIL_BIT = 7;
   localparam int FLAG_BUSY_BIT = 6;
   localparam int FLAG_INIT_BIT = 1;
   localparam int FLAG_RESV_BIT = 0;
   localparam logic [7:0] FLAG_RESET = 8'h00;
   // Interrupt event bits
   localparam int INT_W = 3;
   localparam int INT_STOP_BIT = 0;
   localparam int INT_START_BIT = 1;
   localparam int INT_FAIL_BIT = 2;
   localparam logic [INT_W-1:0] INT_RESET = 3'h0;
   // Synchroniser depth for the bus pins
   localparam int SYNC_STAGES = 2;
endpackage

// ===== design/ibsf_cond_if.sv
`timescale 1ns/100ps
// Bus condition events passed from the detector to the flag logic
interface ibsf_cond_if;
   logic startSeen; // Start condition, one-cycle pulse
   logic stopSeen;  // Stop condition, one-cycle pulse
   logic sclRise;   // Rising clock line, one-cycle pulse
   modport det (output startSeen, output stopSeen, output sclRise);
   modport use_side (input startSeen, input stopSeen, input sclRise);
endinterface

// ===== design/ibsf_cond_det.sv
`timescale 1ns/100ps
module ibsf_cond_det
   import ibsf_pkg::*;
#(
   parameter int SYNC_N = SYNC_STAGES
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Bus pins, asynchronous
   input wire logic sclPin,
   input wire logic sdaPin,
   // Condition events
   ibsf_cond_if.det cond
);
   // Depth check
   if (SYNC_N < 2) begin : g_chk
      $error("SYNC_N must be at least 2");
   end

   logic [SYNC_N-1:0] sclSync_r; // Clock line synchroniser chain
   logic [SYNC_N-1:0] sdaSync_r; // Data line synchroniser chain
   logic sclPrev_r; // Previous synchronised clock level
   logic sdaPrev_r; // Previous synchronised data level
   logic startSeen_r;
   logic stopSeen_r;
   logic sclRise_r;

   // Synchronised levels, last stage only
   wire logic sclNow = sclSync_r[SYNC_N-1];
   wire logic sdaNow = sdaSync_r[SYNC_N-1];
   // Data falls or rises while clock stays high
   wire logic sdaFall = sdaPrev_r & ~sdaNow;
   wire logic sdaRise = ~sdaPrev_r & sdaNow;
   wire logic sclHigh = sclPrev_r & sclNow;

   // Synchronisers and history; idle bus reads high
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         sclSync_r <= '1;
         sdaSync_r <= '1;
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
      end else begin
         sclSync_r <= {sclSync_r[SYNC_N-2:0], sclPin};
         sdaSync_r <= {sdaSync_r[SYNC_N-2:0], sdaPin};
         sclPrev_r <= sclNow;
         sdaPrev_r <= sdaNow;
      end
   end

   // Registered condition pulses
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         startSeen_r <= 1'b0;
         stopSeen_r <= 1'b0;
         sclRise_r <= 1'b0;
      end else begin
         startSeen_r <= sclHigh & sdaFall;
         stopSeen_r <= sclHigh & sdaRise;
         sclRise_r <= ~sclPrev_r & sclNow;
      end
   end

   assign cond.startSeen = startSeen_r;
   assign cond.stopSeen = stopSeen_r;
   assign cond.sclRise = sclRise_r;
endmodule

// ===== design/ibsf_flags.sv
// What this block does
// - Stop condition sets the stop-detected flag
// - First address clock after start clears it
// - Disable falling edge and reset clear it
// - Flag register resets zero; fixed bit layout
// - Failure and busy bits ignore software writes
// - Mode bits writable only while disabled
// - Busy, no reservation: drop request, flag failure
// - Busy set on start, cleared on stop
// - Enable sets busy unless initial start enabled
// - Start permitted only while bus released
// - Initial start enable cleared by stop
// - Reservation disable changes only by software
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/100ps
module ibsf_flags
   import ibsf_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Avalon-MM slave
   input wire logic [ADDR_W-1:0] avsAddress,
   input wire logic avsRead,
   input wire logic avsWrite,
   input wire logic [31:0] avsWritedata,
   input wire logic [3:0] avsByteenable,
   output logic [31:0] avsReaddata,
   output logic avsWaitrequest,
   // Two-wire bus pins, sampled only
   input wire logic sclPin,
   input wire logic sdaPin,
   // Start generation permit to the bus engine
   output logic startGo,
   // Interrupt
   output logic irq
);
   // Condition events from the detector
   ibsf_cond_if cond ();

   ibsf_cond_det #(
      .SYNC_N(SYNC_STAGES)
   ) u_det (
      .clk_sys(clk_sys),
      .srst(srst),
      .sclPin(sclPin),
      .sdaPin(sdaPin),
      .cond(cond)
   );

   // Bus slave state
   logic ack_r; // Second cycle of an access
   logic [31:0] readData_r;
   // Control state
   logic enable_r;     // Interface enable
   logic enablePrev_r; // Enable one cycle ago
   logic startReq_r;   // Pending start request
   logic startGo_r;
   // Flag state
   logic stopFlag_r;  // Stop detected
   logic addrArm_r;   // Waiting for first address clock
   logic failFlag_r;  // Start failure
   logic busyFlag_r;  // Bus busy
   logic initEn_r;    // Initial start enable
   logic resvDis_r;   // Reservation disable
   // Interrupt state
   logic [INT_W-1:0] intStat_r;
   logic [INT_W-1:0] intEn_r;
   logic irq_r;

   // Access handshake: one wait cycle, then accept
   wire logic access = avsRead | avsWrite;
   assign avsWaitrequest = access & ~ack_r;
   wire logic wrAccept = avsWrite & ack_r;
   wire logic rdLoad = avsRead & ~ack_r;
   wire logic wrLow = wrAccept & avsByteenable[0];
   wire logic [15:0] regIdx = avsAddress[ADDR_W-1:2];

   // Address decode
   wire logic selCtrl = regIdx == IDX_CTRL;
   wire logic selStat = regIdx == IDX_STAT;
   wire logic selFlag = regIdx == IDX_FLAG;
   wire logic selIntStat = regIdx == IDX_INT_STAT;
   wire logic selIntClr = regIdx == IDX_INT_CLR;
   wire logic selIntEn = regIdx == IDX_INT_EN;

   // Write strobes
   wire logic wrCtrl = wrLow & selCtrl;
   // Flag write reaches mode bits only
   wire logic wrFlag = wrLow & selFlag;
   wire logic wrIntClr = wrLow & selIntClr;
   wire logic wrIntEn = wrLow & selIntEn;
   wire logic reqWrite = wrCtrl & avsWritedata[CTRL_START_BIT];
   wire logic exitPulse = wrCtrl & avsWritedata[CTRL_EXIT_BIT];

   // Enable edges, seen one cycle after the write
   wire logic enRise = enable_r & ~enablePrev_r;
   wire logic enFall = ~enable_r & enablePrev_r;

   // Bus events count only while enabled
   wire logic startEv = cond.startSeen & enable_r;
   wire logic stopEv = cond.stopSeen & enable_r;
   wire logic addrClk = addrArm_r & cond.sclRise;

   wire logic permit = enable_r & ~busyFlag_r;
   wire logic failEv = startReq_r & enable_r & busyFlag_r & resvDis_r;

   // Register read values
   // Flag layout, bits 5..2 zero
   wire logic [7:0] flagVal = {failFlag_r, busyFlag_r, 4'h0,
                               initEn_r, resvDis_r};
   wire logic [7:0] ctrlVal = {enable_r, 5'h00, startReq_r, 1'b0};
   wire logic [7:0] statVal = {7'h00, stopFlag_r};
   wire logic [7:0] intStatVal = {5'h00, intStat_r};
   wire logic [7:0] intEnVal = {5'h00, intEn_r};
   wire logic [7:0] rdByte = selCtrl ? ctrlVal :
                             selStat ? statVal :
                             selFlag ? flagVal :
                             selIntStat ? intStatVal :
                             selIntEn ? intEnVal : 8'h00;

   // Next values of the flag state
   logic startReq_nxt;
   logic failFlag_nxt;
   logic busyFlag_nxt;
   logic stopFlag_nxt;
   logic addrArm_nxt;
   logic initEn_nxt;
   logic resvDis_nxt;
   logic [INT_W-1:0] intEv;
   logic [INT_W-1:0] intStat_nxt;

   // Request, failure and busy next values
   always_comb begin
      // Request dropped on failure, start, exit or disable
      if (!enable_r || exitPulse || failEv || startEv) begin
         startReq_nxt = 1'b0;
      end else if (reqWrite) begin
         startReq_nxt = 1'b1;
      end else begin
         startReq_nxt = startReq_r;
      end
      if (failEv) begin
         failFlag_nxt = 1'b1;
      end else if (reqWrite || !enable_r) begin
         failFlag_nxt = 1'b0;
      end else begin
         failFlag_nxt = failFlag_r;
      end
      if (!enable_r) begin
         busyFlag_nxt = 1'b0;
      end else if (startEv || (enRise && !initEn_r)) begin
         busyFlag_nxt = 1'b1;
      end else if (stopEv || enRise) begin
         busyFlag_nxt = 1'b0;
      end else begin
         busyFlag_nxt = busyFlag_r;
      end
   end

   // Stop flag, mode bits and interrupt next values
   always_comb begin
      if (enFall) begin
         stopFlag_nxt = 1'b0;
      end else if (stopEv) begin
         stopFlag_nxt = 1'b1;
      end else if (addrClk) begin
         stopFlag_nxt = 1'b0;
      end else begin
         stopFlag_nxt = stopFlag_r;
      end
      // Armed by start until the next clock rise
      if (!enable_r || addrClk) begin
         addrArm_nxt = 1'b0;
      end else if (startEv) begin
         addrArm_nxt = 1'b1;
      end else begin
         addrArm_nxt = addrArm_r;
      end
      if (stopEv) begin
         initEn_nxt = 1'b0;
      end else if (wrFlag && !enable_r) begin
         initEn_nxt = avsWritedata[FLAG_INIT_BIT];
      end else begin
         initEn_nxt = initEn_r;
      end
      if (wrFlag && !enable_r) begin
         resvDis_nxt = avsWritedata[FLAG_RESV_BIT];
      end else begin
         resvDis_nxt = resvDis_r;
      end
      // Sticky events; a new event beats the clear
      intEv = '0;
      intEv[INT_STOP_BIT] = stopEv;
      intEv[INT_START_BIT] = startEv;
      intEv[INT_FAIL_BIT] = failEv;
      intStat_nxt = intStat_r;
      if (wrIntClr) begin
         intStat_nxt = intStat_r & ~avsWritedata[INT_W-1:0];
      end
      intStat_nxt = intStat_nxt | intEv;
   end

   // Bus slave registers
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ack_r <= 1'b0;
         readData_r <= 32'h00000000;
      end else begin
         ack_r <= access & ~ack_r;
         if (rdLoad) begin
            readData_r <= {24'h000000, rdByte};
         end
      end
   end

   // Control registers
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         enable_r <= 1'b0;
         enablePrev_r <= 1'b0;
         startGo_r <= 1'b0;
      end else begin
         enablePrev_r <= enable_r;
         if (wrCtrl) begin
            enable_r <= avsWritedata[CTRL_ENABLE_BIT];
         end
         startGo_r <= startReq_r & permit;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         startReq_r <= 1'b0;
         failFlag_r <= FLAG_RESET[FLAG_FAIL_BIT];
         busyFlag_r <= FLAG_RESET[FLAG_BUSY_BIT];
         initEn_r <= FLAG_RESET[FLAG_INIT_BIT];
         resvDis_r <= FLAG_RESET[FLAG_RESV_BIT];
         stopFlag_r <= 1'b0;
         addrArm_r <= 1'b0;
      end else begin
         startReq_r <= startReq_nxt;
         failFlag_r <= failFlag_nxt;
         busyFlag_r <= busyFlag_nxt;
         initEn_r <= initEn_nxt;
         resvDis_r <= resvDis_nxt;
         stopFlag_r <= stopFlag_nxt;
         addrArm_r <= addrArm_nxt;
      end
   end

   // Interrupt registers
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         intStat_r <= INT_RESET;
         intEn_r <= INT_RESET;
         irq_r <= 1'b0;
      end else begin
         intStat_r <= intStat_nxt;
         if (wrIntEn) begin
            intEn_r <= avsWritedata[INT_W-1:0];
         end
         irq_r <= |(intStat_r & intEn_r);
      end
   end

   assign avsReaddata = readData_r;
   assign startGo = startGo_r;
   assign irq = irq_r;

   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (srst);

   AST_STOP_SET: assert property (stopEv && !enFall |=> stopFlag_r)
      else $error("stop flag not set after stop");
   AST_ADDR_CLR: assert property (
      addrArm_r && cond.sclRise && !stopEv |=> !stopFlag_r)
      else $error("stop flag not cleared at address clock");
   AST_DIS_CLR: assert property (
      enFall |=> !stopFlag_r && !busyFlag_r && !failFlag_r)
      else $error("flags not cleared on disable");
   AST_RO_BITS: assert property (
      wrFlag && !failEv && !reqWrite && !startEv && !stopEv && !enRise
      && enable_r |=> $stable(failFlag_r) && $stable(busyFlag_r))
      else $error("read-only flag changed by write");
   AST_LOCK: assert property (
      wrFlag && enable_r && !stopEv |=> $stable(initEn_r)
      && $stable(resvDis_r))
      else $error("mode bit written while enabled");
   AST_FAIL: assert property (failEv |=> failFlag_r && !startReq_r)
      else $error("refused start not flagged");
   AST_BUSY: assert property (startEv |=> busyFlag_r ##1 busyFlag_r
      || $past(stopEv) || !enable_r)
      else $error("busy not set on start");
   AST_EN_BUSY: assert property (
      enRise && !initEn_r |=> busyFlag_r)
      else $error("busy not set on enable");
   AST_INIT_CLR: assert property (stopEv |=> !initEn_r)
      else $error("initial start enable kept after stop");
   AST_GO: assert property (startGo_r |-> !$past(busyFlag_r)
      && $past(enable_r))
      else $error("start permitted on busy bus");
endmodule

// ===== tb/ibsf_bus_partner.sv
`timescale 1ns/100ps
// Other master on the two-wire bus; this model drives the lines high when idle
module ibsf_bus_partner (
   // Bus lines, high when released
   output logic scl,
   output logic sda
);
   // Half period of the 64 ns link clock
   localparam int HALF = 32;
   // Both lines released at time zero
   initial begin
      scl = 1'h1;
      sda = 1'h1;
   end
   // Start: data falls while clock high
   // Lines move by non-blocking assignment so no edge races them
   task automatic genStart();
      sda <= 1'h0;
      #HALF scl <= 1'h0;
      #HALF;
   endtask
   // One data bit, data set while clock low
   task automatic genBit(input logic b);
      sda <= b;
      #HALF scl <= 1'h1;
      #HALF scl <= 1'h0;
   endtask
   // Stop: data rises while clock high; clock then stands high
   task automatic genStop();
      sda <= 1'h0;
      #HALF scl <= 1'h1;
      #HALF sda <= 1'h1;
      #HALF;
   endtask
endmodule

// ===== tb/tb_i2c_bus_status_flags.sv
`timescale 1ns/100ps
module tb_i2c_bus_status_flags import ibsf_pkg::*;;
   // Clock, reset and register bus drive
   logic clk_sys = 1'h0;
   logic srst = 1'h1;
   logic [ADDR_W-1:0] avsAddress = '0;
   logic avsRead = 1'h0;
   logic avsWrite = 1'h0;
   logic [31:0] avsWritedata = 32'h0;
   logic [3:0] avsByteenable = 4'h1;
   // Design outputs
   logic [31:0] avsReaddata;
   logic avsWaitrequest;
   logic startGo;
   logic irq;
   // Bus lines from the partner
   wire sclPin;
   wire sdaPin;
   // Bookkeeping
   int err_total = 0;
   int n_tests = 0;
   int cyc = 0;
   logic [31:0] rd;

   // Device under test
   ibsf_flags ibsf_flags_i (.clk_sys(clk_sys), .srst(srst),
      .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
      .avsWritedata(avsWritedata), .avsByteenable(avsByteenable),
      .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest),
      .sclPin(sclPin), .sdaPin(sdaPin), .startGo(startGo), .irq(irq));
   // Far-side master
   ibsf_bus_partner ibsf_bus_partner_i (.scl(sclPin), .sda(sdaPin));

   // 125 MHz clock
   always #4 clk_sys = ~clk_sys;

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One register access; held until waitrequest is sampled low
   task automatic acc(input logic [15:0] idx, input logic wr,
         input logic [7:0] d);
      @(posedge clk_sys);
      avsAddress <= {idx, 2'h0};
      avsWrite <= wr;
      avsRead <= ~wr;
      avsWritedata <= {24'h0, d};
      // Sample waitrequest at every edge, the first one too
      do begin
         @(posedge clk_sys);
      end while (avsWaitrequest !== 1'h0);
      rd = avsReaddata;
      avsWrite <= 1'h0;
      avsRead <= 1'h0;
   endtask

   // Read and compare
   task automatic rchk(input logic [15:0] idx, input logic [31:0] exp);
      acc(idx, 1'h0, 8'h00);
      chk(rd, exp);
   endtask

   // Let bus events pass the synchroniser
   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   // Verdict and end of run
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Hang guard
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         tally_and_finish();
      end
   end

   // Test sequence
   initial begin
      idle(4);
      srst <= 1'h0;
      // Reset values and unmapped place
      rchk(IDX_FLAG, 32'h0);
      rchk(IDX_STAT, 32'h0);
      rchk(16'h0001, 32'h0);
      $display("test 1 done");
      // Writes while disabled; status bits and gaps stay zero
      acc(IDX_FLAG, 1'h1, 8'hff);
      rchk(IDX_FLAG, 32'h03);
      acc(IDX_INT_EN, 1'h1, 8'h06);
      $display("test 2 done");
      // Enable with initial start: bus counted as released
      acc(IDX_CTRL, 1'h1, 8'h80);
      rchk(IDX_FLAG, 32'h03);
      acc(IDX_FLAG, 1'h1, 8'h00);
      rchk(IDX_FLAG, 32'h03);
      // Bus seen idle by software before the first request
      acc(IDX_CTRL, 1'h1, 8'h82);
      idle(4);
      chk({31'h0, startGo}, 32'h1);
      $display("test 3 done");
      // Another master takes the bus
      ibsf_bus_partner_i.genStart();
      idle(10);
      rchk(IDX_FLAG, 32'h43);
      // Request with reservation off while busy fails
      acc(IDX_CTRL, 1'h1, 8'h82);
      idle(4);
      rchk(IDX_FLAG, 32'hc3);
      chk({31'h0, startGo}, 32'h0);
      rchk(IDX_INT_STAT, 32'h06);
      chk({31'h0, irq}, 32'h1);
      acc(IDX_INT_CLR, 1'h1, 8'h06);
      idle(2);
      chk({31'h0, irq}, 32'h0);
      $display("test 4 done");
      // Stop: busy and initial start drop, failure stays
      ibsf_bus_partner_i.genBit(1'h1);
      ibsf_bus_partner_i.genStop();
      idle(10);
      rchk(IDX_FLAG, 32'h81);
      rchk(IDX_STAT, 32'h01);
      rchk(IDX_INT_STAT, 32'h01);
      chk({31'h0, irq}, 32'h0);
      acc(IDX_INT_CLR, 1'h1, 8'h01);
      // New request clears the failure flag
      acc(IDX_CTRL, 1'h1, 8'h82);
      idle(4);
      rchk(IDX_FLAG, 32'h01);
      chk({31'h0, startGo}, 32'h1);
      $display("test 5 done");
      // Stop flag held across start until first address clock
      ibsf_bus_partner_i.genStart();
      idle(10);
      rchk(IDX_STAT, 32'h01);
      ibsf_bus_partner_i.genBit(1'h0);
      idle(10);
      rchk(IDX_STAT, 32'h00);
      ibsf_bus_partner_i.genStop();
      idle(10);
      rchk(IDX_STAT, 32'h01);
      // Disable clears the stop flag; busy and failure are already zero here
      acc(IDX_CTRL, 1'h1, 8'h00);
      idle(2);
      rchk(IDX_STAT, 32'h00);
      rchk(IDX_FLAG, 32'h01);
      $display("test 6 done");
      // No initial start: busy until a stop is seen
      acc(IDX_FLAG, 1'h1, 8'h00);
      rchk(IDX_FLAG, 32'h00);
      acc(IDX_CTRL, 1'h1, 8'h80);
      rchk(IDX_FLAG, 32'h40);
      acc(IDX_CTRL, 1'h1, 8'h82);
      idle(4);
      chk({31'h0, startGo}, 32'h0);
      rchk(IDX_FLAG, 32'h40);
      rchk(IDX_CTRL, 32'h82);
      // Exit from communication drops the pending request
      acc(IDX_CTRL, 1'h1, 8'hc0);
      rchk(IDX_CTRL, 32'h80);
      ibsf_bus_partner_i.genStart();
      ibsf_bus_partner_i.genStop();
      idle(10);
      rchk(IDX_FLAG, 32'h00);
      chk({31'h0, startGo}, 32'h0);
      // Fresh request once the stop has been seen
      acc(IDX_CTRL, 1'h1, 8'h82);
      idle(4);
      chk({31'h0, startGo}, 32'h1);
      $display("test 7 done");
      tally_and_finish();
   end
endmodule
